// [pdcg_pkg.sv]
// Constants, types and shared decoding for the clock generation block.
// Operation
// - Multiply input clock by one, two, four.
// - Factor comes from two-bit multiplier field.
// - Internal rising edge aligned to input pin.
// - Mode 0 applies factor after standby entry.
// - Deferred switch counts exit wait by select.
// - Factor one after reset.
// - Standby entry stops clock, loads new factor.
// - Exit waits transition time, then resumes.
// - Mode 1 applies new factor immediately.
// - Divide by two up to thirty-two.
// - Peripherals and exit wait use divided clock.
// - Control writes change clock despite transfers.
// - High-speed plus six power-down modes.
// - High-speed mode after reset.
// - Sleep, division, module stop may combine.
// - Multiplier codes 00, 01, 10; 11 unused.
// - Divider codes 000 to 101; 11X prohibited.
package pdcg_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADDR_SYS_CLOCK_CTRL = 5'h00;
  localparam logic [4:0] ADDR_PLL_CTRL = 5'h04;
  localparam logic [4:0] ADDR_STANDBY_CTRL = 5'h08;
  localparam logic [4:0] ADDR_MODULE_STOP = 5'h0c;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam int MULT_SWITCH_BIT = 3;
  localparam int STANDBY_ENABLE_BIT = 7;
  localparam logic [1:0] MULT_X1 = 2'h0;
  localparam logic [1:0] MULT_X2 = 2'h1;
  localparam logic [1:0] MULT_X4 = 2'h2;
  localparam logic [1:0] MULT_BAD = 2'h3;
  localparam logic [2:0] DIV_MAX = 3'h5;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam int WAIT_W = 20;
  localparam logic [19:0] WAIT_BASE = 20'h00010;
  localparam logic [31:0] SYS_CLOCK_CTRL_REG_MASK = 32'h000000cf;
  localparam logic [31:0] PLL_CTRL_REG_MASK = 32'h0000000b;
  localparam logic [31:0] STANDBY_CTRL_REG_MASK = 32'h0000008f;
  localparam logic [31:0] MSTOP_MASK = 32'h00000003;

  typedef enum logic [1:0] {
    PDCG_RUN = 2'b00,
    PDCG_STANDBY = 2'b01,
    PDCG_EXIT_WAIT = 2'b11
  } pdcg_state_e;

  typedef struct packed {
    logic highSpeed;
    logic clockDivision;
    logic sleep;
    logic moduleStop;
    logic allModuleStop;
    logic swStandby;
    logic hwStandby;
  } pdcg_mode_s;

  // Exit wait in divided-clock ticks: sixteen doubled per select step.
  function automatic logic [19:0] pdcg_wait_ticks(input logic [3:0] sel);
    pdcg_wait_ticks = WAIT_BASE << sel;
  endfunction

  // Divider mask: ones for the low bits counted within one period.
  function automatic logic [4:0] pdcg_div_mask(input logic [2:0] sel);
    pdcg_div_mask = 5'(6'h01 << sel) - 5'h01;
  endfunction
endpackage

// [pdcg_top.sv]
// Clock generator: PLL factor, divider, standby sequencing, register slave.
`timescale 1ns/1ns
module pdcg_top
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [pdcg_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic extClockInPin,
  input wire logic sleepInstr,
  input wire logic wakeReq,
  input wire logic hwStandbyReq,
  output logic pllTick,
  output logic sysClkTick,
  output pdcg_pkg::pdcg_mode_s modeFlags
);
  import pdcg_pkg::*;

  logic [7:0] sysClockCtrl_reg;
  logic [7:0] pllCtrl_reg;
  logic [7:0] standbyCtrl_reg;
  logic [1:0] moduleStop_reg;
  logic [1:0] activeMult_reg;
  logic [2:0] activeDiv_reg;
  logic [4:0] divCnt_reg;
  logic [1:0] phaseCnt_reg;
  logic [2:0] extSync_reg;
  logic extLevel_reg;
  logic [2:0] hwSync_reg;
  logic hwLevel_reg;
  logic sleep_reg;
  logic ack_reg;
  logic [WAIT_W-1:0] waitCnt_reg;
  pdcg_state_e state_reg;
  pdcg_state_e state_next;
  logic access;
  logic wrStrobe;
  logic extRise;
  logic divBoundary;
  logic waitDone;
  logic [1:0] multSel;
  logic [2:0] divSel;

  assign multSel = pllCtrl_reg[1:0];
  assign divSel = sysClockCtrl_reg[2:0];

  //////////////////////////////////////////////////////////////////////////
  // Register slave: one wait state, write takes effect when it completes.

  assign access = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack_reg;
  assign wrStrobe = avs_write & ack_reg;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= access & ~ack_reg;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h00000000;
    else if (avs_read & ~ack_reg)
    begin
      unique case (avs_address)
        ADDR_SYS_CLOCK_CTRL: avs_readdata <= {24'h000000, sysClockCtrl_reg};
        ADDR_PLL_CTRL: avs_readdata <= {24'h000000, pllCtrl_reg};
        ADDR_STANDBY_CTRL: avs_readdata <= {24'h000000, standbyCtrl_reg};
        ADDR_MODULE_STOP: avs_readdata <= {30'h00000000, moduleStop_reg};
        ADDR_STATUS:
          avs_readdata <= {20'h00000, state_reg, activeDiv_reg,
                           activeMult_reg, 5'h00};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Writes land regardless of bus traffic elsewhere; the clock follows.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sysClockCtrl_reg <= 8'h00;
      pllCtrl_reg <= 8'h00;
      standbyCtrl_reg <= 8'h00;
      moduleStop_reg <= 2'h0;
    end
    else if (wrStrobe)
    begin
      unique case (avs_address)
        ADDR_SYS_CLOCK_CTRL:
          sysClockCtrl_reg <= avs_writedata[7:0] & SYS_CLOCK_CTRL_REG_MASK[7:0];
        ADDR_PLL_CTRL:
          pllCtrl_reg <= avs_writedata[7:0] & PLL_CTRL_REG_MASK[7:0];
        ADDR_STANDBY_CTRL:
          standbyCtrl_reg <= avs_writedata[7:0] & STANDBY_CTRL_REG_MASK[7:0];
        ADDR_MODULE_STOP: moduleStop_reg <= avs_writedata[1:0];
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Input pin sampling; the first stage feeds only the second.

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      extSync_reg <= 3'h0;
      hwSync_reg <= 3'h0;
    end
    else
    begin
      extSync_reg <= {extSync_reg[1:0], extClockInPin};
      hwSync_reg <= {hwSync_reg[1:0], hwStandbyReq};
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      extLevel_reg <= 1'b0;
      hwLevel_reg <= 1'b0;
    end
    else
    begin
      if (extSync_reg[1] == extSync_reg[2])
        extLevel_reg <= extSync_reg[2];
      if (hwSync_reg[1] == hwSync_reg[2])
        hwLevel_reg <= hwSync_reg[2];
    end
  end

  assign extRise = (extSync_reg[1] == extSync_reg[2]) & extSync_reg[2]
                   & ~extLevel_reg;

  //////////////////////////////////////////////////////////////////////////
  // PLL model: the input period spans four mclk phases; the factor picks
  // how many of them carry an output edge. A filtered pin rise restarts
  // the phase so the internal edge stays aligned to the pin.

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      phaseCnt_reg <= 2'h0;
    else if (extRise)
      phaseCnt_reg <= 2'h0;
    else
      phaseCnt_reg <= phaseCnt_reg + 2'h1;
  end

  always_comb
  begin
    unique case (activeMult_reg)
      MULT_X2: pllTick = ~phaseCnt_reg[0];
      MULT_X4: pllTick = 1'b1;
      default: pllTick = (phaseCnt_reg == 2'h0);
    endcase
  end

  // Factor one from reset; code 11 is ignored and the old factor stays.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      activeMult_reg <= MULT_X1;
    else if (multSel != MULT_BAD)
    begin
      if (sysClockCtrl_reg[MULT_SWITCH_BIT])
        activeMult_reg <= multSel;
      else if (state_reg == PDCG_STANDBY)
        activeMult_reg <= multSel;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Divider. The ratio changes only when a whole divided period ends,
  // which keeps every system clock period at least as long as the
  // faster of the old and new settings.

  assign divBoundary = pllTick
                       & (divCnt_reg == pdcg_div_mask(activeDiv_reg));

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      divCnt_reg <= 5'h00;
    else if (divBoundary)
      divCnt_reg <= 5'h00;
    else if (pllTick)
      divCnt_reg <= divCnt_reg + 5'h01;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      activeDiv_reg <= 3'h0;
    else if (divBoundary && divSel <= DIV_MAX)
      activeDiv_reg <= divSel;
  end

  // Peripheral tick: stopped through standby and the exit wait.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sysClkTick <= 1'b0;
    else
      sysClkTick <= divBoundary & (state_reg == PDCG_RUN)
                    & (state_next == PDCG_RUN) & ~hwLevel_reg;
  end

  //////////////////////////////////////////////////////////////////////////
  // Standby sequencing.

  assign waitDone = divBoundary
                    & (waitCnt_reg >= pdcg_wait_ticks(standbyCtrl_reg[3:0]));

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      PDCG_RUN:
        if (sleepInstr && standbyCtrl_reg[STANDBY_ENABLE_BIT])
          state_next = PDCG_STANDBY;
      PDCG_STANDBY:
        if (wakeReq)
          state_next = PDCG_EXIT_WAIT;
      PDCG_EXIT_WAIT:
        if (waitDone)
          state_next = PDCG_RUN;
      default: state_next = PDCG_RUN;
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      state_reg <= PDCG_RUN;
    else
      state_reg <= state_next;
  end

  // Exit wait counted in divided ticks, so it scales with the ratio.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      waitCnt_reg <= '0;
    else if (state_reg != PDCG_EXIT_WAIT)
      waitCnt_reg <= '0;
    else if (divBoundary)
      waitCnt_reg <= waitCnt_reg + 20'h00001;
  end

  // Sleep without standby enable; a wake request ends it.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sleep_reg <= 1'b0;
    else if (sleepInstr && !standbyCtrl_reg[STANDBY_ENABLE_BIT])
      sleep_reg <= 1'b1;
    else if (wakeReq)
      sleep_reg <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Operating mode report; the CPU-side modes may be set together.

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      modeFlags <= '0;
    else
    begin
      modeFlags.clockDivision <= (activeDiv_reg != 3'h0);
      modeFlags.sleep <= sleep_reg;
      modeFlags.moduleStop <= moduleStop_reg[0];
      modeFlags.allModuleStop <= moduleStop_reg[1];
      modeFlags.swStandby <= (state_reg != PDCG_RUN);
      modeFlags.hwStandby <= hwLevel_reg;
      modeFlags.highSpeed <= (activeDiv_reg == 3'h0) & ~sleep_reg
                             & (moduleStop_reg == 2'h0)
                             & (state_reg == PDCG_RUN) & ~hwLevel_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_enterStandby;
    state_reg == PDCG_RUN && sleepInstr && standbyCtrl_reg[STANDBY_ENABLE_BIT];
  endsequence

  sequence s_inStandby;
    state_reg == PDCG_STANDBY;
  endsequence

  property p_deferLoad;
    @(posedge mclk) disable iff (rst)
      s_enterStandby ##1 (s_inStandby and (multSel != MULT_BAD
                          && !sysClockCtrl_reg[MULT_SWITCH_BIT]))
      |=> activeMult_reg == $past(multSel);
  endproperty
  a_deferLoad: assert property (p_deferLoad)
    else $error("Factor not loaded in standby.");

  property p_deferHold;
    @(posedge mclk) disable iff (rst)
      state_reg == PDCG_RUN && !sysClockCtrl_reg[MULT_SWITCH_BIT]
      |=> $stable(activeMult_reg);
  endproperty
  a_deferHold: assert property (p_deferHold)
    else $error("Factor changed outside standby.");

  property p_immediate;
    @(posedge mclk) disable iff (rst)
      sysClockCtrl_reg[MULT_SWITCH_BIT] && multSel != MULT_BAD
      |=> activeMult_reg == $past(multSel);
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("Immediate factor not applied.");

  property p_noTickStandby;
    @(posedge mclk) disable iff (rst)
      state_reg != PDCG_RUN |=> !sysClkTick;
  endproperty
  a_noTickStandby: assert property (p_noTickStandby)
    else $error("System tick during standby.");

  property p_exitWait;
    @(posedge mclk) disable iff (rst)
      state_reg == PDCG_EXIT_WAIT && $past(state_reg) == PDCG_EXIT_WAIT
      && state_next == PDCG_RUN
      |-> waitCnt_reg >= pdcg_wait_ticks(standbyCtrl_reg[3:0]);
  endproperty
  a_exitWait: assert property (p_exitWait)
    else $error("Standby left before wait elapsed.");

  property p_divBoundary;
    @(posedge mclk) disable iff (rst)
      $changed(activeDiv_reg) |-> $past(divBoundary);
  endproperty
  a_divBoundary: assert property (p_divBoundary)
    else $error("Ratio changed mid period.");

  property p_x1Rate;
    @(posedge mclk) disable iff (rst)
      activeMult_reg == MULT_X1 && pllTick && !extRise ##1 !extRise
      |-> !pllTick;
  endproperty
  a_x1Rate: assert property (p_x1Rate)
    else $error("Factor one ticks too fast.");

  property p_align;
    @(posedge mclk) disable iff (rst)
      extRise |=> phaseCnt_reg == 2'h0 && pllTick;
  endproperty
  a_align: assert property (p_align)
    else $error("Output edge not aligned to pin.");

  property p_legalDiv;
    @(posedge mclk) disable iff (rst)
      activeDiv_reg <= DIV_MAX && activeMult_reg != MULT_BAD;
  endproperty
  a_legalDiv: assert property (p_legalDiv)
    else $error("Prohibited setting applied.");

  property p_bus;
    @(posedge mclk) disable iff (rst)
      access && !ack_reg |=> !avs_waitrequest;
  endproperty
  a_bus: assert property (p_bus)
    else $error("Bus answer late.");

endmodule // pdcg_top

// [pdcg_osc_model.sv]
// Behavioural input oscillator that drives the clock input pin.
`timescale 1ns/1ns
module pdcg_osc_model
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic holdHigh,
  output logic clkPin
);
  logic [1:0] phaseReg;

  // Four fast cycles per period keep the source inside its band.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      phaseReg <= 2'h0;
    else
      phaseReg <= phaseReg + 2'h1;
  end

  // The pin stands high while the device sleeps in standby.
  assign clkPin = holdHigh | ~phaseReg[1];
endmodule // pdcg_osc_model

// [tb_pll_divider_clock_gen.sv]
// Self-checking bench for the clock generation block.
`timescale 1ns/1ns
module tb_pll_divider_clock_gen;
  import pdcg_pkg::*;
  logic mclk, rst, rdReq, wrReq, waitReq, slp, wake, hws, pin, pll, sck;
  logic [4:0] adr;
  logic [31:0] wData, rData;
  pdcg_mode_s mode;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  pdcg_top DUT (.mclk(mclk), .rst(rst), .avs_address(adr),
    .avs_read(rdReq), .avs_write(wrReq), .avs_writedata(wData),
    .avs_readdata(rData), .avs_waitrequest(waitReq),
    .extClockInPin(pin), .sleepInstr(slp), .wakeReq(wake),
    .hwStandbyReq(hws), .pllTick(pll), .sysClkTick(sck),
    .modeFlags(mode));

  pdcg_osc_model osc (.mclk(mclk), .rst(rst),
    .holdHigh(mode.swStandby | mode.hwStandby), .clkPin(pin));

  ////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Waitrequest and read data are taken at the rising edge; one idle
  // edge follows so the strobes are never reassigned in one time step.
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] q);
    adr <= a;
    wData <= d;
    wrReq <= w;
    rdReq <= ~w;
    do
      @(posedge mclk);
    while (waitReq !== 1'b0);
    q = rData;
    wrReq <= 1'b0;
    rdReq <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input string n, input logic [4:0] a,
    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask

  task automatic stat(input logic [1:0] m, input logic [2:0] d,
    input logic [1:0] s);
    rchk("status", ADDR_STATUS, {20'h0, s, d, m, 5'h0});
  endtask

  task automatic pulse(input bit toWake);
    if (toWake)
      wake <= 1'b1;
    else
      slp <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    slp <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic count(input int n, output int p, output int s);
    p = 0;
    s = 0;
    repeat (n)
    begin
      @(negedge mclk);
      p += (pll === 1'b1);
      s += (sck === 1'b1);
    end
    @(posedge mclk);
  endtask

  task automatic period(output int p);
    p = 0;
    do
      @(negedge mclk);
    while (sck !== 1'b1);
    do
    begin
      @(negedge mclk);
      p++;
    end
    while (sck !== 1'b1);
    @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("highSpeed", 32'h1, mode.highSpeed);
    stat(MULT_X1, 3'h0, 2'h0);
    rchk("sysCtrl", ADDR_SYS_CLOCK_CTRL, 32'h0);
    rchk("pllCtrl", ADDR_PLL_CTRL, 32'h0);
    rchk("stbyCtrl", ADDR_STANDBY_CTRL, 32'h0);
  endtask

  task automatic t_regs();
    wreg(ADDR_SYS_CLOCK_CTRL, 32'hff);
    rchk("sysCtrl", ADDR_SYS_CLOCK_CTRL, 32'hcf);
    wreg(ADDR_PLL_CTRL, 32'hff);
    rchk("pllCtrl", ADDR_PLL_CTRL, 32'h0b);
    stat(MULT_X1, 3'h0, 2'h0);
    wreg(ADDR_STANDBY_CTRL, 32'hff);
    rchk("stbyCtrl", ADDR_STANDBY_CTRL, 32'h8f);
    wreg(5'h14, 32'hff);
    rchk("unmapped", 5'h14, 32'h0);
    wreg(ADDR_STANDBY_CTRL, 32'h0);
    wreg(ADDR_PLL_CTRL, 32'h0);
  endtask

  task automatic t_mult();
    int p, s;
    wreg(ADDR_SYS_CLOCK_CTRL, 32'h8);
    for (int m = 0; m < 3; m++)
    begin
      wreg(ADDR_PLL_CTRL, m);
      stat(m[1:0], 3'h0, 2'h0);
      count(16, p, s);
      chk("pllTicks", 32'(4 << m), p);
    end
  endtask

  // The factor is now four, so one divided period is 2**d cycles.
  task automatic t_div();
    int p;
    for (int d = 1; d < 6; d++)
    begin
      wreg(ADDR_SYS_CLOCK_CTRL, 32'h8 | d);
      period(p);
      chk("divPeriod", 32'(1 << d), p);
      stat(MULT_X4, d[2:0], 2'h0);
      chk("clockDivision", 32'h1, mode.clockDivision);
    end
  endtask

  task automatic t_standby();
    int p, s;
    wreg(ADDR_SYS_CLOCK_CTRL, 32'h0);
    // The old 1/32 ratio must run out before the new one is reported.
    period(p);
    period(p);
    chk("undivided", 32'h1, p);
    wreg(ADDR_PLL_CTRL, MULT_X2);
    stat(MULT_X4, 3'h0, 2'h0);
    wreg(ADDR_STANDBY_CTRL, 32'h80);
    pulse(1'b0);
    chk("swStandby", 32'h1, mode.swStandby);
    stat(MULT_X2, 3'h0, 2'h1);
    count(40, p, s);
    chk("stbyTicks", 32'h0, s);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    p = 0;
    do
    begin
      @(negedge mclk);
      p++;
    end
    while (sck !== 1'b1 && p < 200);
    @(posedge mclk);
    chk("exitWait", 32'h1, (p >= 32 && p <= 48));
    stat(MULT_X2, 3'h0, 2'h0);
  endtask

  task automatic t_modes();
    int p, s;
    wreg(ADDR_STANDBY_CTRL, 32'h0);
    pulse(1'b0);
    wreg(ADDR_MODULE_STOP, 32'h3);
    @(posedge mclk);
    chk("sleep", 32'h1, mode.sleep);
    chk("moduleStop", 32'h1, mode.moduleStop);
    chk("allModuleStop", 32'h1, mode.allModuleStop);
    chk("highSpeedOff", 32'h0, mode.highSpeed);
    pulse(1'b1);
    chk("sleepOff", 32'h0, mode.sleep);
    wreg(ADDR_MODULE_STOP, 32'h0);
    hws <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("hwStandby", 32'h1, mode.hwStandby);
    count(16, p, s);
    chk("hwTicks", 32'h0, s);
    hws <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // A hang anywhere counts as a failure and closes the run.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  initial
  begin
    rst = 1'b1;
    rdReq = 1'b0;
    wrReq = 1'b0;
    adr = 5'h0;
    wData = 32'h0;
    slp = 1'b0;
    wake = 1'b0;
    hws = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    t_reset();
    t_regs();
    t_mult();
    t_div();
    t_standby();
    t_modes();
    end_of_test();
  end
endmodule // tb_pll_divider_clock_gen
